//--- verilog/hcp_regs.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * hidden mode configuration registers and the AUI decoder.
 * Assumes a 125 MHz system clock and a 20 MHz oscillator figure.
 */
`ifndef HCP_REGS_SVH
`define HCP_REGS_SVH

// Register indices; byte address is four times the index
`define HCP_IDX_CFG_A 6'h0a
`define HCP_IDX_CFG_B 6'h0b

// Mode configuration register B fields
`define HCP_B_PHY_LO 0
`define HCP_B_PHY_HI 1
`define HCP_B_LINK 2
`define HCP_B_BERR 5

// Reset values
`define HCP_CFG_A_RST 8'h00
`define HCP_CFG_B_RST 8'h00
`define HCP_RBC_RST 8'h00

// Rates in MHz for the fractional divider
`define HCP_OSC_MHZ 8'h14
`define HCP_CLK_MHZ 8'h7d

// Decoder and collision timing, in 10 MHz bit times
`define HCP_RX_VALID_BITS 4'h6
`define HCP_EOF_BITS 4'h2
`define HCP_CD_ACT_BITS 4'h2

`endif

//--- verilog/hcp_pkg.sv
/*
 * Types shared by the hidden configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package hcp_pkg;
    typedef enum logic [1:0] {
        HCP_PHY_TP_STD = 2'h0,
        HCP_PHY_THICK = 2'h1,
        HCP_PHY_THIN = 2'h2,
        HCP_PHY_TP_RED = 2'h3
    } hcp_phy_t;

    typedef enum logic [2:0] {
        HCP_DEC_IDLE = 3'h1,
        HCP_DEC_LOCK = 3'h2,
        HCP_DEC_DATA = 3'h4
    } hcp_dec_t;
endpackage
`default_nettype wire

//--- verilog/hcp_top.sv
/*
 * Hidden mode configuration registers A and B behind page-0 indices
 * 0x0a and 0x0b, the physical interface selection register B steers, the
 * 10 MHz bit clock enable, the AUI end-of-frame and lock timing and
 * the collision translator.
 * Assumes a classic Wishbone master, pins that are asynchronous to
 * clk_i, and tx_active_i and bus_err_event_i from logic on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hcp_regs.svh"

module hcp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic aui_rx_i,
    input wire logic aui_collision_pair_i,
    input wire logic tp_link_pass_i,
    input wire logic tx_active_i,
    input wire logic bus_err_event_i,
    output logic [7:0] mode_config_a_o,
    output hcp_pkg::hcp_phy_t phy_interface_select_o,
    output logic tp_select_o,
    output logic thin_enable_o,
    output logic squelch_reduced_o,
    output logic link_pulse_en_o,
    output logic link_good_led_o,
    output logic [7:0] rbc0_o,
    output logic [7:0] rbc1_o,
    output logic tx_clk_en_o,
    output logic rx_data_valid_o,
    output logic rx_frame_end_o,
    output logic backoff_o,
    output logic collision_led_o
);
    import hcp_pkg::*;

    function automatic logic is_aui(input hcp_phy_t p);
        is_aui = (p == HCP_PHY_THICK) || (p == HCP_PHY_THIN);
    endfunction

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bit clock enable

    logic [7:0] acc_r, acc_nxt;
    logic half_r, half_nxt;
    logic tick_r, tick_nxt;
    logic [7:0] acc_sum;

    // Fractional divider: 125 MHz has no integer ratio to 20 MHz
    always_comb begin
        acc_sum = acc_r + `HCP_OSC_MHZ;
        acc_nxt = acc_sum;
        half_nxt = half_r;
        tick_nxt = 1'b0;
        if (acc_sum >= `HCP_CLK_MHZ) begin
            acc_nxt = acc_sum - `HCP_CLK_MHZ;
            half_nxt = ~half_r;
            tick_nxt = half_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= 8'h00;
            half_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            half_r <= half_nxt;
            tick_r <= tick_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [2:0] rx_s_r, cd_s_r, lk_s_r;
    logic [2:0] rx_s_nxt, cd_s_nxt, lk_s_nxt;
    logic rx_f_r, cd_f_r, lk_f_r, rx_d_r, cd_d_r;
    logic rx_f_nxt, cd_f_nxt, lk_f_nxt;

    // A change counts only once stages two and three agree
    always_comb begin
        rx_s_nxt = {rx_s_r[1:0], aui_rx_i};
        cd_s_nxt = {cd_s_r[1:0], aui_collision_pair_i};
        lk_s_nxt = {lk_s_r[1:0], tp_link_pass_i};
        rx_f_nxt = (rx_s_r[1] == rx_s_r[2]) ? rx_s_r[2] : rx_f_r;
        cd_f_nxt = (cd_s_r[1] == cd_s_r[2]) ? cd_s_r[2] : cd_f_r;
        lk_f_nxt = (lk_s_r[1] == lk_s_r[2]) ? lk_s_r[2] : lk_f_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s_r <= 3'h0;
            cd_s_r <= 3'h0;
            lk_s_r <= 3'h0;
            rx_f_r <= 1'b0;
            cd_f_r <= 1'b0;
            lk_f_r <= 1'b0;
            rx_d_r <= 1'b0;
            cd_d_r <= 1'b0;
        end else begin
            rx_s_r <= rx_s_nxt;
            cd_s_r <= cd_s_nxt;
            lk_s_r <= lk_s_nxt;
            rx_f_r <= rx_f_nxt;
            cd_f_r <= cd_f_nxt;
            lk_f_r <= lk_f_nxt;
            rx_d_r <= rx_f_r;
            cd_d_r <= cd_f_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register bus and hidden registers

    logic [7:0] cfg_a_r, cfg_a_nxt, cfg_b_r, cfg_b_nxt;
    logic [7:0] rbc0_r, rbc0_nxt, rbc1_r, rbc1_nxt;
    logic arm_a_r, arm_a_nxt, arm_b_r, arm_b_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic link_r, link_nxt;
    logic take, hit_a, hit_b, wr0;
    logic [7:0] b_view;

    always_comb begin
        take = wb_cyc_i && wb_stb_i && !ack_r;
        hit_a = (wb_adr_i[7:2] == `HCP_IDX_CFG_A);
        hit_b = (wb_adr_i[7:2] == `HCP_IDX_CFG_B);
        wr0 = take && wb_we_i && wb_sel_i[0];
        b_view = cfg_b_r;
        b_view[`HCP_B_LINK] = link_r;
        cfg_a_nxt = cfg_a_r;
        cfg_b_nxt = cfg_b_r;
        rbc0_nxt = rbc0_r;
        rbc1_nxt = rbc1_r;
        arm_a_nxt = arm_a_r;
        arm_b_nxt = arm_b_r;
        ack_nxt = take;
        dat_nxt = 32'h0000_0000;
        if (take) begin
            // Any access disarms; only a read of the same index rearms
            arm_a_nxt = hit_a && !wb_we_i;
            arm_b_nxt = hit_b && !wb_we_i;
            if (!wb_we_i && hit_a) begin
                dat_nxt[7:0] = cfg_a_r;
            end
            if (!wb_we_i && hit_b) begin
                dat_nxt[7:0] = b_view;
            end
        end
        if (wr0 && hit_a) begin
            if (arm_a_r) begin
                cfg_a_nxt = wb_dat_i[7:0];
            end else begin
                rbc0_nxt = wb_dat_i[7:0];
            end
        end
        if (wr0 && hit_b) begin
            if (arm_b_r) begin
                cfg_b_nxt = wb_dat_i[7:0];
                // Bus error is write-one-to-clear; writing back a read clears it
                cfg_b_nxt[`HCP_B_BERR] = cfg_b_r[`HCP_B_BERR] && !wb_dat_i[`HCP_B_BERR];
            end else begin
                rbc1_nxt = wb_dat_i[7:0];
            end
        end
        // A new error beats a clear in the same cycle
        if (bus_err_event_i) begin
            cfg_b_nxt[`HCP_B_BERR] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_a_r <= `HCP_CFG_A_RST;
            cfg_b_r <= `HCP_CFG_B_RST;
            rbc0_r <= `HCP_RBC_RST;
            rbc1_r <= `HCP_RBC_RST;
            arm_a_r <= 1'b0;
            arm_b_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            cfg_a_r <= cfg_a_nxt;
            cfg_b_r <= cfg_b_nxt;
            rbc0_r <= rbc0_nxt;
            rbc1_r <= rbc1_nxt;
            arm_a_r <= arm_a_nxt;
            arm_b_r <= arm_b_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interface selection and link status

    hcp_phy_t phy;
    logic aui;
    logic link_dis;
    hcp_phy_t phy_r;
    logic tp_r, thin_r, sq_r, lpe_r;
    logic tp_nxt, thin_nxt, sq_nxt, lpe_nxt;

    always_comb begin
        phy = hcp_phy_t'(cfg_b_r[`HCP_B_PHY_HI:`HCP_B_PHY_LO]);
        aui = is_aui(phy);
        link_dis = cfg_b_r[`HCP_B_LINK];
        tp_nxt = !aui;
        thin_nxt = (phy == HCP_PHY_THIN);
        sq_nxt = (phy == HCP_PHY_TP_RED);
        lpe_nxt = !aui && !link_dis;
        if (aui) begin
            link_nxt = 1'b0;
        end else if (link_dis) begin
            link_nxt = 1'b1;
        end else begin
            link_nxt = lk_f_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_r <= HCP_PHY_TP_STD;
            tp_r <= 1'b1;
            thin_r <= 1'b0;
            sq_r <= 1'b0;
            lpe_r <= 1'b1;
            link_r <= 1'b0;
        end else begin
            phy_r <= phy;
            tp_r <= tp_nxt;
            thin_r <= thin_nxt;
            sq_r <= sq_nxt;
            lpe_r <= lpe_nxt;
            link_r <= link_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AUI decoder timing

    hcp_dec_t dec_r, dec_nxt;
    logic [3:0] sil_r, sil_nxt, bits_r, bits_nxt;
    logic eof_r, eof_nxt, val_r, val_nxt;
    logic rx_edge;

    // Bit-time resolution only; jitter inside a bit is not judged here
    always_comb begin
        rx_edge = rx_f_r ^ rx_d_r;
        dec_nxt = dec_r;
        sil_nxt = sil_r;
        bits_nxt = bits_r;
        eof_nxt = 1'b0;
        if (rx_edge) begin
            sil_nxt = 4'h0;
        end else if (tick_r) begin
            sil_nxt = sat_inc(sil_r);
        end
        unique case (dec_r)
            HCP_DEC_IDLE: begin
                bits_nxt = 4'h0;
                if (rx_edge && aui) begin
                    dec_nxt = HCP_DEC_LOCK;
                end
            end
            HCP_DEC_LOCK: begin
                if (tick_r) begin
                    bits_nxt = sat_inc(bits_r);
                end
                if (sil_r >= `HCP_EOF_BITS || !aui) begin
                    dec_nxt = HCP_DEC_IDLE;
                end else if (tick_r && bits_r == `HCP_RX_VALID_BITS - 4'h1) begin
                    dec_nxt = HCP_DEC_DATA;
                end
            end
            HCP_DEC_DATA: begin
                if (sil_r >= `HCP_EOF_BITS || !aui) begin
                    dec_nxt = HCP_DEC_IDLE;
                    eof_nxt = 1'b1;
                end
            end
        endcase
        val_nxt = (dec_nxt == HCP_DEC_DATA);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_r <= HCP_DEC_IDLE;
            sil_r <= 4'hf;
            bits_r <= 4'h0;
            eof_r <= 1'b0;
            val_r <= 1'b0;
        end else begin
            dec_r <= dec_nxt;
            sil_r <= sil_nxt;
            bits_r <= bits_nxt;
            eof_r <= eof_nxt;
            val_r <= val_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Collision translator

    logic [3:0] cds_r, cds_nxt;
    logic col_r, col_nxt, boff_r, boff_nxt;
    logic cd_act;

    // Heartbeat comes after transmit ends on a quiet net, so gating by
    // activity keeps it, and a missing cable, off the LED
    always_comb begin
        cds_nxt = cds_r;
        if (cd_f_r ^ cd_d_r) begin
            cds_nxt = 4'h0;
        end else if (tick_r) begin
            cds_nxt = sat_inc(cds_r);
        end
        cd_act = (cds_r < `HCP_CD_ACT_BITS);
        col_nxt = aui && cd_act && (tx_active_i || dec_r != HCP_DEC_IDLE);
        boff_nxt = aui && cd_act && tx_active_i && !col_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cds_r <= 4'hf;
            col_r <= 1'b0;
            boff_r <= 1'b0;
        end else begin
            cds_r <= cds_nxt;
            col_r <= col_nxt;
            boff_r <= boff_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        wb_dat_o = dat_r;
        wb_ack_o = ack_r;
        mode_config_a_o = cfg_a_r;
        phy_interface_select_o = phy_r;
        tp_select_o = tp_r;
        thin_enable_o = thin_r;
        squelch_reduced_o = sq_r;
        link_pulse_en_o = lpe_r;
        link_good_led_o = link_r;
        rbc0_o = rbc0_r;
        rbc1_o = rbc1_r;
        tx_clk_en_o = tick_r;
        rx_data_valid_o = val_r;
        rx_frame_end_o = eof_r;
        backoff_o = boff_r;
        collision_led_o = col_r;
    end
endmodule
`default_nettype wire

//--- sim/hcp_properties.sv
/*
 * Port checker for hcp_top: bus timing, steering of hidden writes,
 * mode pins, link bit, decoder and collision outputs.
 * Assumes it is bound to hcp_top by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module hcp_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] mode_config_a_o,
    input wire hcp_pkg::hcp_phy_t phy_interface_select_o,
    input wire logic tp_select_o,
    input wire logic thin_enable_o,
    input wire logic squelch_reduced_o,
    input wire logic link_pulse_en_o,
    input wire logic link_good_led_o,
    input wire logic [7:0] rbc0_o,
    input wire logic [7:0] rbc1_o,
    input wire logic rx_data_valid_o,
    input wire logic rx_frame_end_o,
    input wire logic backoff_o,
    input wire logic collision_led_o
);
    import hcp_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    dat_zero_a: assert property (
        wb_ack_o && !(wb_adr_i[7:2] inside {6'h0a, 6'h0b}) |-> wb_dat_o == 32'h0)
        else $error("read data on other index");
    a_write_a: assert property (
        $changed(mode_config_a_o) |-> wb_ack_o && wb_we_i && wb_adr_i == 8'h28)
        else $error("register A changed without write");
    rbc0_write_a: assert property (
        $changed(rbc0_o) |-> wb_ack_o && wb_we_i && wb_adr_i == 8'h28)
        else $error("byte count 0 changed without write");
    rbc1_write_a: assert property (
        $changed(rbc1_o) |-> wb_ack_o && wb_we_i && wb_adr_i == 8'h2c)
        else $error("byte count 1 changed without write");
    mode_pins_a: assert property (
        tp_select_o == (phy_interface_select_o inside {HCP_PHY_TP_STD, HCP_PHY_TP_RED})
        && thin_enable_o == (phy_interface_select_o == HCP_PHY_THIN)
        && squelch_reduced_o == (phy_interface_select_o == HCP_PHY_TP_RED))
        else $error("mode pins disagree with selection");
    link_aui_a: assert property (!tp_select_o [*2] |-> !link_good_led_o)
        else $error("link lit in AUI mode");
    pulse_tp_a: assert property (link_pulse_en_o |-> tp_select_o)
        else $error("link pulses outside twisted pair");
    backoff_led_a: assert property (backoff_o |-> collision_led_o ##1 !backoff_o)
        else $error("backoff without collision");
    col_aui_a: assert property (collision_led_o |-> !tp_select_o)
        else $error("collision lit outside AUI");
    frame_end_a: assert property (
        rx_frame_end_o |-> $past(rx_data_valid_o) ##1 !rx_frame_end_o)
        else $error("frame end without data");
endmodule
`default_nettype wire

//--- sim/hcp_top_bench.sv
/*
 * Self-checking bench for hcp_top.
 * Assumes the design and hcp_properties are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module hcp_top_bench;
    import hcp_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic aui_rx_i = 0, aui_collision_pair_i = 0, tp_link_pass_i = 1;
    logic tx_active_i = 0, bus_err_event_i = 0, wb_ack_o, tx_clk_en_o;
    logic [7:0] wb_adr_i = 8'h00, mode_config_a_o, rbc0_o, rbc1_o, v, rd_e, bval = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic tp_select_o, thin_enable_o, squelch_reduced_o, link_pulse_en_o, link_good_led_o;
    logic rx_data_valid_o, rx_frame_end_o, backoff_o, collision_led_o, errf = 0;
    hcp_phy_t phy_interface_select_o;
    int errors = 0, n_tests = 0, seed = 80, n_bo = 0, n_led = 0, n_eof = 0, n_tk = 0, t0;
    logic [7:0] rq[$];
    hcp_top uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .aui_rx_i(aui_rx_i),
        .aui_collision_pair_i(aui_collision_pair_i),
        .tp_link_pass_i(tp_link_pass_i),
        .tx_active_i(tx_active_i),
        .bus_err_event_i(bus_err_event_i),
        .mode_config_a_o(mode_config_a_o),
        .phy_interface_select_o(phy_interface_select_o),
        .tp_select_o(tp_select_o),
        .thin_enable_o(thin_enable_o),
        .squelch_reduced_o(squelch_reduced_o),
        .link_pulse_en_o(link_pulse_en_o),
        .link_good_led_o(link_good_led_o),
        .rbc0_o(rbc0_o),
        .rbc1_o(rbc1_o),
        .tx_clk_en_o(tx_clk_en_o),
        .rx_data_valid_o(rx_data_valid_o),
        .rx_frame_end_o(rx_frame_end_o),
        .backoff_o(backoff_o),
        .collision_led_o(collision_led_o)
    );
    initial forever #4 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////
    task close_out;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Read data is taken at the ack edge only
    always @(posedge clk_i) begin
        // Pop once: the macro names its expected value twice
        if (wb_ack_o && !wb_we_i) begin
            rd_e = rq.pop_front();
            `CHK(wb_dat_o, {24'h0, rd_e})
        end
        n_bo += backoff_o;
        n_led += collision_led_o;
        n_eof += rx_frame_end_o;
        n_tk += tx_clk_en_o;
    end
    function automatic logic [7:0] exp_b();
        logic l;
        l = (bval[1:0] inside {2'h1, 2'h2}) ? 1'b0 : (bval[2] | tp_link_pass_i);
        return {bval[7:6], errf, bval[4:3], l, bval[1:0]};
    endfunction
    task bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        k = 0;
        do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) errors++;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task rd(input logic [7:0] adr, input logic [7:0] e);
        rq.push_back(e);
        bus(1'b0, adr, 8'h00);
    endtask
    // Fresh values only, never the read value written back
    task bset(input logic [7:0] d);
        rd(8'h2c, exp_b());
        bus(1'b1, 8'h2c, d);
        bval = d;
        if (d[5]) errf = 0;
        repeat (8) @(posedge clk_i);
    endtask
    task wiggle(input int n, input logic rx, input logic cd);
        repeat (n) begin
            repeat (6) @(posedge clk_i);
            aui_rx_i <= aui_rx_i ^ rx;
            aui_collision_pair_i <= aui_collision_pair_i ^ cd;
        end
    endtask
    initial begin
        #100us;
        errors++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        repeat (10) @(posedge clk_i);
        rd(8'h28, 8'h00);
        v = 8'($random(seed));
        bus(1'b1, 8'h28, v);
        `CHK(mode_config_a_o, v)
        rd(8'h28, v);
        rd(8'h2c, exp_b());
        bus(1'b1, 8'h28, 8'h5a);
        `CHK({rbc0_o, mode_config_a_o}, {8'h5a, v})
        rd(8'h2c, exp_b());
        rd(8'h00, 8'h00);
        bus(1'b1, 8'h2c, 8'ha5);
        `CHK({rbc1_o, phy_interface_select_o}, {8'ha5, HCP_PHY_TP_STD})
        for (int m = 0; m < 4; m++) begin
            bset(8'(m));
            `CHK(phy_interface_select_o, hcp_phy_t'(m))
            `CHK({thin_enable_o, squelch_reduced_o}, {m == 2, m == 3})
            `CHK({5'h00, link_good_led_o, 2'h0}, exp_b() & 8'h04)
            rd(8'h2c, exp_b());
        end
        bset(8'h00);
        tp_link_pass_i <= 0;
        repeat (10) @(posedge clk_i);
        `CHK({link_good_led_o, link_pulse_en_o}, 2'b01)
        rd(8'h2c, exp_b());
        bset(8'h04);
        `CHK({link_good_led_o, link_pulse_en_o}, 2'b10)
        rd(8'h2c, exp_b());
        bus_err_event_i <= 1;
        @(posedge clk_i);
        bus_err_event_i <= 0;
        errf = 1;
        bset(8'h21);
        t0 = n_tk;
        rd(8'h2c, exp_b());
        repeat (250) @(posedge clk_i);
        `CHK((n_tk - t0) inside {[19:21]}, 1'b1)
        wiggle(20, 1'b1, 1'b0);
        `CHK({rx_data_valid_o, n_eof == 0}, 2'b11)
        repeat (60) @(posedge clk_i);
        `CHK({rx_data_valid_o, n_eof == 1}, 2'b01)
        tx_active_i <= 1;
        wiggle(10, 1'b0, 1'b1);
        `CHK({collision_led_o, n_bo == 1}, 2'b11)
        tx_active_i <= 0;
        repeat (60) @(posedge clk_i);
        t0 = n_led;
        wiggle(5, 1'b0, 1'b1);
        `CHK(n_led == t0, 1'b1)
        close_out;
    end
endmodule
bind hcp_top hcp_properties chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mode_config_a_o(mode_config_a_o),
    .phy_interface_select_o(phy_interface_select_o),
    .tp_select_o(tp_select_o),
    .thin_enable_o(thin_enable_o),
    .squelch_reduced_o(squelch_reduced_o),
    .link_pulse_en_o(link_pulse_en_o),
    .link_good_led_o(link_good_led_o),
    .rbc0_o(rbc0_o),
    .rbc1_o(rbc1_o),
    .rx_data_valid_o(rx_data_valid_o),
    .rx_frame_end_o(rx_frame_end_o),
    .backoff_o(backoff_o),
    .collision_led_o(collision_led_o)
);
`default_nettype wire
